// File: sensor_interrupt_pin_control_test.sv
// self-checking bench for the interrupt pin control block and a host model
// assumes one-cycle read data and one-cycle pin latency
`timescale 1ns/1ps
`default_nettype none
`include "sipc_consts.svh"
module sensor_interrupt_pin_control_test;
    logic        i_sys_clk = 1'b0;
    logic        i_rstn    = 1'b0;
    logic [7:0]  addr      = 8'h00;
    logic [7:0]  wdata     = 8'h00;
    logic [7:0]  flags     = 8'h00;
    logic        wr        = 1'b0;
    wire logic [7:0] rdata;
    wire logic   pa, pa_oe, pb, pb_oe, line_a, line_b;
    int          failures  = 0;
    int          comparisons = 0;
    logic [31:0] seed      = 32'h8e121d6b;
    logic [7:0]  cfg, en, rt, v;
    logic [8:0]  notes[$];
    logic [8:0]  note;
    // ----------------------------------------------------------------
    // clock, design and host
    // ----------------------------------------------------------------
    always #12.5 i_sys_clk = ~i_sys_clk;
    sipc_pin_control dut (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_reg_addr(addr), .i_reg_wr(wr),
        .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_event_flags(flags), .o_irq_pin_a(pa),
        .o_irq_pin_a_oe(pa_oe), .o_irq_pin_b(pb), .o_irq_pin_b_oe(pb_oe));
    sipc_host_model host (.i_pin_a(pa), .i_pin_a_oe(pa_oe), .i_pin_b(pb), .i_pin_b_oe(pb_oe),
        .o_line_a(line_a), .o_line_b(line_b));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] rnd();
        repeat (8) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction : rnd
    // expected {pin a, oe a, pin b, oe b, line a, line b} from the bench's own register copy
    function automatic logic [5:0] exp_pins(input logic [7:0] f);
        logic qa, qb, va, vb, oa, ob;
        qa = |(f & en & rt);
        qb = |(f & en & ~rt);
        va = qa ? cfg[5] : ~cfg[5];
        vb = qb ? cfg[1] : ~cfg[1];
        oa = ~cfg[4] | qa;
        ob = ~cfg[0] | qb;
        return {va, oa, vb, ob, oa ? va : 1'b1, ob ? vb : 1'b1};
    endfunction : exp_pins
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge i_sys_clk);
        wr    <= 1'b0;
    endtask : wr_reg
    // read data reflects the address seen one edge earlier
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_sys_clk);
        addr <= a;
        @(posedge i_sys_clk);
        notes.push_back({1'b0, e});
    endtask : rd_reg
    task automatic pins(input logic [7:0] f);
        @(posedge i_sys_clk);
        flags <= f;
        @(posedge i_sys_clk);
        notes.push_back({3'b100, exp_pins(f)});
    endtask : pins
    task automatic chk_reg(input logic [7:0] e);
        comparisons++;
        if (rdata !== e)
        begin
            failures++;
            $display("BAD rdata expected %h seen %h", e, rdata);
        end
    endtask : chk_reg
    task automatic chk_pin(input logic [5:0] e);
        comparisons++;
        if ({pa, pa_oe, pb, pb_oe, line_a, line_b} !== e)
        begin
            failures++;
            $display("BAD pins expected %b seen %b", e, {pa, pa_oe, pb, pb_oe, line_a, line_b});
        end
    endtask : chk_pin
    task automatic end_sim();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_sim
    // ----------------------------------------------------------------
    // monitor: oldest note against settled outputs
    // ----------------------------------------------------------------
    always @(negedge i_sys_clk)
        while (notes.size() > 0)
        begin
            note = notes.pop_front();
            if (note[8])
                chk_pin(note[5:0]);
            else
                chk_reg(note[7:0]);
        end
    // watchdog well past the roughly one thousand cycles the tests need
    initial
    begin
        #125000;
        failures++;
        end_sim();
    end
    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial
    begin
        cfg = 8'h00;
        en  = 8'h00;
        rt  = 8'h00;
        repeat (3) @(posedge i_sys_clk);
        i_rstn <= 1'b1;
        pins(8'hff);
        rd_reg(`SIPC_ADDR_PIN_CONFIG, 8'h00);
        rd_reg(`SIPC_ADDR_SOURCE_ENABLE, 8'h00);
        rd_reg(`SIPC_ADDR_PIN_ROUTING, 8'h00);
        wr_reg(`SIPC_ADDR_PIN_CONFIG, 8'hff);
        rd_reg(`SIPC_ADDR_PIN_CONFIG, 8'h33);
        wr_reg(8'h2b, 8'h5a);
        rd_reg(8'h2b, 8'h00);
        cfg = 8'h33;
        $display("test reset_and_map done");
        // random settings draw polarity, drive type, enable and route values afresh in each of 60 rounds
        repeat (60)
        begin
            v   = rnd();
            cfg = v & 8'h33;
            en  = rnd();
            rt  = rnd();
            wr_reg(`SIPC_ADDR_PIN_CONFIG, v);
            wr_reg(`SIPC_ADDR_SOURCE_ENABLE, en);
            wr_reg(`SIPC_ADDR_PIN_ROUTING, rt);
            rd_reg(`SIPC_ADDR_PIN_CONFIG, cfg);
            rd_reg(`SIPC_ADDR_SOURCE_ENABLE, en);
            rd_reg(`SIPC_ADDR_PIN_ROUTING, rt);
            pins(rnd());
            pins(8'h00);
        end
        $display("test random_routing done");
        // reset in mid-run: every register clears and both pins return to idle push-pull high
        @(posedge i_sys_clk);
        i_rstn <= 1'b0;
        cfg = 8'h00;
        en  = 8'h00;
        rt  = 8'h00;
        repeat (2) @(posedge i_sys_clk);
        notes.push_back({3'b100, exp_pins(8'h00)});
        i_rstn <= 1'b1;
        pins(8'hff);
        rd_reg(`SIPC_ADDR_PIN_CONFIG, 8'h00);
        rd_reg(`SIPC_ADDR_SOURCE_ENABLE, 8'h00);
        rd_reg(`SIPC_ADDR_PIN_ROUTING, 8'h00);
        $display("test mid_run_reset done");
        // two falling edges, so the monitor has taken the last note before the verdict
        repeat (2) @(negedge i_sys_clk);
        end_sim();
    end
endmodule : sensor_interrupt_pin_control_test
`default_nettype wire

// File: sipc_consts.svh
// constants for the sensor interrupt pin control block
// assumes inclusion by bare name from the design file and the bench
`ifndef SIPC_CONSTS_SVH
`define SIPC_CONSTS_SVH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define SIPC_ADDR_PIN_CONFIG    8'h28
`define SIPC_ADDR_SOURCE_ENABLE 8'h29
`define SIPC_ADDR_PIN_ROUTING   8'h2a

// ----------------------------------------------------------------
// field positions and masks
// ----------------------------------------------------------------
`define SIPC_BIT_PIN_A_POLARITY   5
`define SIPC_BIT_PIN_A_DRIVE_TYPE 4
`define SIPC_BIT_PIN_B_POLARITY   1
`define SIPC_BIT_PIN_B_DRIVE_TYPE 0
`define SIPC_CONFIG_WRITE_MASK    8'h33

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SIPC_RESET_PIN_CONFIG    8'h00
`define SIPC_RESET_SOURCE_ENABLE 8'h00
`define SIPC_RESET_PIN_ROUTING   8'h00

`endif

// File: sipc_host_model.sv
// host side model: watches both interrupt lines through board pull-ups
// assumes the pin control block splits each pin into a value and a drive enable
`timescale 1ns/1ps
`default_nettype none
module sipc_host_model (
    // pin a from the device
    input  wire logic i_pin_a,
    input  wire logic i_pin_a_oe,
    // pin b from the device
    input  wire logic i_pin_b,
    input  wire logic i_pin_b_oe,
    // line levels as the host sees them
    output var  logic o_line_a,
    output var  logic o_line_b
);
    // ----------------------------------------------------------------
    // line resolution
    // ----------------------------------------------------------------
    // a released line is pulled high, so a stale value never shows through
    assign o_line_a = i_pin_a_oe ? i_pin_a : 1'b1;
    assign o_line_b = i_pin_b_oe ? i_pin_b : 1'b1;
endmodule : sipc_host_model
`default_nettype wire

// File: sipc_pin_control.sv
// interrupt pin control: enable, routing, polarity and drive type of two pins
// assumes the serial register front end gives a one-cycle write strobe and a
// synchronous address; event flags are levels from logic on the same clock
//
// Contract
// - pin a polarity bit 5: 0 active low, 1 active high.
// - pin a drive type bit 4: 0 push-pull, 1 open-drain.
// - pin b polarity bit 1: 0 active low, 1 active high.
// - pin b drive type bit 0: 0 push-pull, 1 open-drain.
// - only enabled source flags reach the pins.
// - each enabled source goes to exactly one pin.
// - enable bit 7 data ready, bit 6 fifo; reset disabled.
// - enable bit 5 pressure window, bit 4 temperature window; reset disabled.
// - enable bit 3 pressure threshold, bit 2 temperature threshold; reset disabled.
// - enable bit 1 pressure change, bit 0 temperature change; reset disabled.
// - routing register, one bit per source, same order, resets to zero.
// - config bits 7:6 and 3:2 read zero, writes ignored.
// - routing bit 0 sends to pin b, 1 sends to pin a.
// - each pin is the or of its routed enabled sources; host reads status.
`timescale 1ns/1ps
`default_nettype none
`include "sipc_consts.svh"

module sipc_pin_control (
    // clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_rstn,
    // register access
    input  wire logic [7:0] i_reg_addr,
    input  wire logic       i_reg_wr,
    input  wire logic [7:0] i_reg_wdata,
    output var  logic [7:0] o_reg_rdata,
    // event flags
    input  wire logic [7:0] i_event_flags,
    // interrupt pin a
    output var  logic       o_irq_pin_a,
    output var  logic       o_irq_pin_a_oe,
    // interrupt pin b
    output var  logic       o_irq_pin_b,
    output var  logic       o_irq_pin_b_oe
);

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    sipc_pkg::sipc_sources_t interrupt_source_enable;
    sipc_pkg::sipc_sources_t interrupt_pin_routing;
    logic [7:0]              interrupt_pin_config;

    // address decode
    wire logic sel_config  = (i_reg_addr == `SIPC_ADDR_PIN_CONFIG);
    wire logic sel_enable  = (i_reg_addr == `SIPC_ADDR_SOURCE_ENABLE);
    wire logic sel_routing = (i_reg_addr == `SIPC_ADDR_PIN_ROUTING);

    // reserved bits never store, so they read back zero
    wire logic [7:0] next_config = i_reg_wdata & `SIPC_CONFIG_WRITE_MASK;

    // field views
    wire sipc_pkg::sipc_drive_t pin_a_drive_type =
        sipc_pkg::sipc_drive_t'(interrupt_pin_config[`SIPC_BIT_PIN_A_DRIVE_TYPE]);
    wire sipc_pkg::sipc_drive_t pin_b_drive_type =
        sipc_pkg::sipc_drive_t'(interrupt_pin_config[`SIPC_BIT_PIN_B_DRIVE_TYPE]);
    wire logic pin_a_polarity = interrupt_pin_config[`SIPC_BIT_PIN_A_POLARITY];
    wire logic pin_b_polarity = interrupt_pin_config[`SIPC_BIT_PIN_B_POLARITY];

    // register writes; every bit clears under reset
    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            interrupt_pin_config    <= `SIPC_RESET_PIN_CONFIG;
            interrupt_source_enable <= `SIPC_RESET_SOURCE_ENABLE;
            interrupt_pin_routing   <= `SIPC_RESET_PIN_ROUTING;
        end
        else if (i_reg_wr)
        begin
            if (sel_config)
                interrupt_pin_config <= next_config;
            else if (sel_enable)
                interrupt_source_enable <= i_reg_wdata;
            else if (sel_routing)
                interrupt_pin_routing <= i_reg_wdata;
        end
    end

    // read mux; unmapped addresses read zero
    wire logic [7:0] next_rdata =
        sel_config  ? interrupt_pin_config :
        sel_enable  ? interrupt_source_enable :
        sel_routing ? interrupt_pin_routing : 8'h00;

    // ----------------------------------------------------------------
    // gating and routing
    // ----------------------------------------------------------------
    // a disabled source is masked before routing, so it touches neither pin
    wire logic [7:0] gated     = i_event_flags & interrupt_source_enable;
    wire logic [7:0] to_pin_a  = gated & interrupt_pin_routing;
    wire logic [7:0] to_pin_b  = gated & ~interrupt_pin_routing;
    wire logic       pending_a = |to_pin_a;
    wire logic       pending_b = |to_pin_b;

    // pin level: polarity flips the asserted level
    wire logic next_pin_a = pending_a ~^ pin_a_polarity;
    wire logic next_pin_b = pending_b ~^ pin_b_polarity;

    // open-drain drives only while asserted; shared lines need an external pull
    wire logic next_oe_a = (pin_a_drive_type == sipc_pkg::SIPC_PUSH_PULL) | pending_a;
    wire logic next_oe_b = (pin_b_drive_type == sipc_pkg::SIPC_PUSH_PULL) | pending_b;

    // output flops; one cycle latency from flag to pin
    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_reg_rdata    <= 8'h00;
            o_irq_pin_a    <= 1'b1; // reset: push-pull, active low, idle high
            o_irq_pin_a_oe <= 1'b1;
            o_irq_pin_b    <= 1'b1;
            o_irq_pin_b_oe <= 1'b1;
        end
        else
        begin
            o_reg_rdata    <= next_rdata;
            o_irq_pin_a    <= next_pin_a;
            o_irq_pin_a_oe <= next_oe_a;
            o_irq_pin_b    <= next_pin_b;
            o_irq_pin_b_oe <= next_oe_b;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------

    // polarity one cycle late, for the idle check below
    logic pin_a_polarity_q;
    logic pin_b_polarity_q;
    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            pin_a_polarity_q <= 1'b0;
            pin_b_polarity_q <= 1'b0;
        end
        else
        begin
            pin_a_polarity_q <= pin_a_polarity;
            pin_b_polarity_q <= pin_b_polarity;
        end
    end

    // every check runs on the system clock and stays quiet while reset is held;
    // registers clear asynchronously, so a $past taken in reset sees cleared values
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);

    // pin level and drive enable against the settings of the cycle before
    AST_PIN_A_POLARITY: assert property (
        o_irq_pin_a_oe |-> (o_irq_pin_a == ($past(pending_a) ~^ $past(pin_a_polarity))))
        else $error("pin a level does not follow polarity");
    AST_PIN_A_PUSH_PULL: assert property (
        $past(pin_a_drive_type) == sipc_pkg::SIPC_PUSH_PULL |-> o_irq_pin_a_oe)
        else $error("pin a released in push-pull");
    AST_PIN_A_OPEN_DRAIN: assert property (
        $past(pin_a_drive_type) == sipc_pkg::SIPC_OPEN_DRAIN && !$past(pending_a) |-> !o_irq_pin_a_oe)
        else $error("pin a driven while idle in open-drain");
    AST_PIN_B_POLARITY: assert property (
        o_irq_pin_b_oe |-> (o_irq_pin_b == ($past(pending_b) ~^ $past(pin_b_polarity))))
        else $error("pin b level does not follow polarity");
    AST_PIN_B_PUSH_PULL: assert property (
        $past(pin_b_drive_type) == sipc_pkg::SIPC_PUSH_PULL |-> o_irq_pin_b_oe)
        else $error("pin b released in push-pull");
    AST_PIN_B_OPEN_DRAIN: assert property (
        $past(pin_b_drive_type) == sipc_pkg::SIPC_OPEN_DRAIN && !$past(pending_b) |-> !o_irq_pin_b_oe)
        else $error("pin b driven while idle in open-drain");

    // open-drain pins drive nothing but the asserted level; a shared line would fight otherwise
    AST_PIN_A_OD_LEVEL: assert property (
        o_irq_pin_a_oe && $past(pin_a_drive_type) == sipc_pkg::SIPC_OPEN_DRAIN
            |-> o_irq_pin_a == $past(pin_a_polarity))
        else $error("pin a open-drain drove the idle level");
    AST_PIN_B_OD_LEVEL: assert property (
        o_irq_pin_b_oe && $past(pin_b_drive_type) == sipc_pkg::SIPC_OPEN_DRAIN
            |-> o_irq_pin_b == $past(pin_b_polarity))
        else $error("pin b open-drain drove the idle level");

    // gating, steering and the or of routed sources
    AST_DISABLED_SILENT: assert property (
        interrupt_source_enable == 8'h00
            |=> (o_irq_pin_a == !pin_a_polarity_q) && (o_irq_pin_b == !pin_b_polarity_q))
        else $error("disabled sources moved a pin");
    AST_ONE_PIN: assert property (
        (to_pin_a & to_pin_b) == 8'h00 && (to_pin_a | to_pin_b) == gated)
        else $error("enabled source not on exactly one pin");
    AST_ROUTE_B: assert property (
        gated != 8'h00 && interrupt_pin_routing == 8'h00 |-> pending_b && !pending_a)
        else $error("routing zero did not select pin b");
    AST_ROUTE_A: assert property (
        gated != 8'h00 && interrupt_pin_routing == 8'hff |-> pending_a && !pending_b)
        else $error("routing one did not select pin a");
    AST_PIN_A_OR: assert property (
        (|(i_event_flags & interrupt_source_enable & interrupt_pin_routing))
            |=> o_irq_pin_a == $past(pin_a_polarity))
        else $error("pin a not asserted for routed source");
    AST_PIN_B_OR: assert property (
        (|(i_event_flags & interrupt_source_enable & ~interrupt_pin_routing))
            |=> o_irq_pin_b == $past(pin_b_polarity))
        else $error("pin b not asserted for routed source");

    // register storage and read path
    AST_RESERVED_ZERO: assert property (
        (interrupt_pin_config & ~`SIPC_CONFIG_WRITE_MASK) == 8'h00)
        else $error("reserved config bit set");
    AST_CONFIG_WRITE: assert property (
        i_reg_wr && sel_config |=> interrupt_pin_config == ($past(i_reg_wdata) & `SIPC_CONFIG_WRITE_MASK))
        else $error("config register write lost");
    AST_ENABLE_WRITE: assert property (
        i_reg_wr && sel_enable |=> interrupt_source_enable == $past(i_reg_wdata))
        else $error("enable register write lost");
    AST_ROUTING_WRITE: assert property (
        i_reg_wr && sel_routing |=> interrupt_pin_routing == $past(i_reg_wdata))
        else $error("routing register write lost");
    AST_ROUTING_READ: assert property (
        sel_routing |=> o_reg_rdata == $past(interrupt_pin_routing))
        else $error("routing register read wrong");

    // main scenarios worth seeing at least once
    COV_PIN_A_HIGH: cover property (pending_a && pin_a_polarity);
    COV_PIN_B_LOW:  cover property (pending_b && !pin_b_polarity);
    COV_OD_RELEASE: cover property (pin_a_drive_type == sipc_pkg::SIPC_OPEN_DRAIN && !o_irq_pin_a_oe);
    COV_BOTH_PINS:  cover property (pending_a && pending_b);

endmodule : sipc_pin_control
`default_nettype wire

// File: sipc_pkg.sv
// types for the sensor interrupt pin control block
// assumes nothing beyond the constants header
`default_nettype none
package sipc_pkg;
    // drive type of an interrupt pin
    typedef enum logic {SIPC_PUSH_PULL, SIPC_OPEN_DRAIN} sipc_drive_t;
    // one bit per event source, data ready at bit 7 down to temperature change at bit 0
    typedef logic [7:0] sipc_sources_t;
endpackage : sipc_pkg
`default_nettype wire
